// >>> verilog/charge_time_unit.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - channel one: sensitivity 1 means edge-triggered, 0 level-triggered
// - channel one: polarity 1 rising/high, 0 falling/low
// - second status flag set by second event; software write drives source
// - first status flag set by first event; software write drives source
// - channel two: sensitivity 1 means edge-triggered, 0 level-triggered
// - channel two: polarity 1 rising/high, 0 falling/low
// - channel two select: timer, compare, pin2, pin1, pins9-13, captures, comparators
// - unimplemented bits read zero and ignore writes
// - trim field is signed two's complement around nominal
// - range 01 base, 10 ten, 11 hundred, 00 thousand times
// - event detection and current source run only while module enable is set
// - edge pass enable clear blocks events from status flags
// - order enable makes second event wait for first
// - ground control ties current source output to ground
module charge_time_unit (
  // clock and reset
  input  wire logic                  clk_sys_i,
  input  wire logic                  arst_n_i,
  // axi4-lite write address
  input  wire logic [3:0]            s_axi_awaddr_i,
  input  wire logic                  s_axi_awvalid_i,
  output logic                       s_axi_awready_o,
  // axi4-lite write data
  input  wire logic [31:0]           s_axi_wdata_i,
  input  wire logic [3:0]            s_axi_wstrb_i,
  input  wire logic                  s_axi_wvalid_i,
  output logic                       s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0]                 s_axi_bresp_o,
  output logic                       s_axi_bvalid_o,
  input  wire logic                  s_axi_bready_i,
  // axi4-lite read address
  input  wire logic [3:0]            s_axi_araddr_i,
  input  wire logic                  s_axi_arvalid_i,
  output logic                       s_axi_arready_o,
  // axi4-lite read data
  output logic [31:0]                s_axi_rdata_o,
  output logic [1:0]                 s_axi_rresp_o,
  output logic                       s_axi_rvalid_o,
  input  wire logic                  s_axi_rready_i,
  // asynchronous trigger sources
  input  wire ctu_pkg::edge_src_t    edge_src_i,
  // analog current source controls
  output ctu_pkg::analog_ctrl_t      analog_o
);
  import ctu_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0] mode_ctrl_q;
  logic [15:0] edge_select_q;
  logic [15:0] current_q;
  logic        e1_stat_q;
  logic        e2_stat_q;

  logic        run;
  logic        pass;
  chan_cfg_t   cfg1;
  chan_cfg_t   cfg2;

  assign run  = mode_ctrl_q[MODE_ENABLE_BIT];
  assign pass = run & mode_ctrl_q[EDGE_PASS_BIT];
  assign cfg1 = '{sens: edge_select_q[E1_SENS_BIT], pol: edge_select_q[E1_POL_BIT],
                  sel: edge_select_q[E1_SEL_LSB +: SEL_W]};
  assign cfg2 = '{sens: edge_select_q[E2_SENS_BIT], pol: edge_select_q[E2_POL_BIT],
                  sel: edge_select_q[E2_SEL_LSB +: SEL_W]};

  //////////////////////////////////////////////////////////////////////////////
  // source synchronisation
  edge_src_t src_s;

  ctu_sync2 #(
    .W($bits(edge_src_t))
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .arst_n_i (arst_n_i),
    .async_i  (edge_src_i),
    .sync_o   (src_s)
  );

  //////////////////////////////////////////////////////////////////////////////
  // source selection
  logic src1;
  logic src2;

  always_comb begin
    case (cfg1.sel)
      4'h0: src1 = src_s.first_timer;
      4'h1: src1 = src_s.ocmp1;
      4'h2: src1 = src_s.pins[1];
      4'h3: src1 = src_s.pins[0];
      4'h4: src1 = src_s.pins[2];
      4'h5: src1 = src_s.pins[3];
      4'h6: src1 = src_s.pins[4];
      4'h7: src1 = src_s.pins[5];
      4'h8: src1 = src_s.pins[6];
      4'h9: src1 = src_s.pins[7];
      4'ha: src1 = src_s.icap[0];
      4'hb: src1 = src_s.icap[1];
      4'hc: src1 = src_s.icap[2];
      4'hd: src1 = src_s.cmp[0];
      4'he: src1 = src_s.cmp[1];
      4'hf: src1 = src_s.cmp[2];
      default: src1 = 1'b0;
    endcase
  end

  // the reserved code feeds a constant low; with inverting polarity in
  // level mode that still fires, which is why software must avoid it
  always_comb begin
    case (cfg2.sel)
      4'h0: src2 = src_s.first_timer;
      4'h1: src2 = src_s.ocmp1;
      4'h2: src2 = src_s.pins[1];
      4'h3: src2 = src_s.pins[0];
      4'h4: src2 = src_s.pins[8];
      4'h5: src2 = src_s.pins[9];
      4'h6: src2 = src_s.pins[10];
      4'h7: src2 = src_s.pins[11];
      4'h8: src2 = src_s.pins[12];
      4'h9: src2 = src_s.icap[0];
      4'ha: src2 = src_s.icap[1];
      4'hb: src2 = src_s.icap[2];
      4'hc: src2 = 1'b0;
      4'hd: src2 = src_s.cmp[0];
      4'he: src2 = src_s.cmp[1];
      4'hf: src2 = src_s.cmp[2];
      default: src2 = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // edge detection
  logic ev1;
  logic ev2;

  ctu_edge_chan u_chan1 (
    .clk_sys_i(clk_sys_i),
    .arst_n_i (arst_n_i),
    .src_i    (src1),
    .cfg_i    (cfg1),
    .run_i    (pass),
    .event_o  (ev1)
  );

  ctu_edge_chan u_chan2 (
    .clk_sys_i(clk_sys_i),
    .arst_n_i (arst_n_i),
    .src_i    (src2),
    .cfg_i    (cfg2),
    .run_i    (pass),
    .event_o  (ev2)
  );

  logic ev2_ok;
  assign ev2_ok = ev2 & (~mode_ctrl_q[EDGE_ORDER_BIT] | e1_stat_q);

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  logic [3:0]  aw_addr_q;
  logic        aw_have_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        w_have_q;
  logic        wr_fire;
  logic [15:0] wmask;
  logic [15:0] wdat;

  assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid_o;
  assign wmask   = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  assign wdat    = w_data_q[15:0];

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_have_q       <= 1'b0;
      aw_addr_q       <= 4'h0;
      s_axi_awready_o <= 1'b1;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_have_q       <= 1'b1;
      aw_addr_q       <= s_axi_awaddr_i;
      s_axi_awready_o <= 1'b0;
    end else if (wr_fire) begin
      aw_have_q       <= 1'b0;
      s_axi_awready_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      w_have_q       <= 1'b0;
      w_data_q       <= 32'h0000_0000;
      w_strb_q       <= 4'h0;
      s_axi_wready_o <= 1'b1;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_have_q       <= 1'b1;
      w_data_q       <= s_axi_wdata_i;
      w_strb_q       <= s_axi_wstrb_i;
      s_axi_wready_o <= 1'b0;
    end else if (wr_fire) begin
      w_have_q       <= 1'b0;
      s_axi_wready_o <= 1'b1;
    end
  end

  logic wr_hit;
  assign wr_hit = (aw_addr_q == ADDR_MODE_CTRL) || (aw_addr_q == ADDR_EDGE_SELECT)
               || (aw_addr_q == ADDR_CURRENT);

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // control registers; unimplemented bits never store
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_ctrl_q   <= REG_RESET;
      edge_select_q <= REG_RESET;
      current_q     <= REG_RESET;
    end else if (wr_fire) begin
      case (aw_addr_q)
        ADDR_MODE_CTRL: mode_ctrl_q <=
          (mode_ctrl_q & ~wmask) | (wdat & wmask & MODE_CTRL_MASK);
        ADDR_EDGE_SELECT: edge_select_q <=
          (edge_select_q & ~wmask) | (wdat & wmask & EDGE_SELECT_MASK);
        ADDR_CURRENT: current_q <=
          (current_q & ~wmask) | (wdat & wmask & CURRENT_MASK);
        default: ;
      endcase
    end
  end

  // status flags: hardware set beats a software clear in the same cycle
  logic stat_wr;
  assign stat_wr = wr_fire & (aw_addr_q == ADDR_EDGE_SELECT) & w_strb_q[1];

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      e1_stat_q <= 1'b0;
    end else if (ev1) begin
      e1_stat_q <= 1'b1;
    end else if (stat_wr) begin
      e1_stat_q <= wdat[E1_STAT_BIT];
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      e2_stat_q <= 1'b0;
    end else if (ev2_ok) begin
      e2_stat_q <= 1'b1;
    end else if (stat_wr) begin
      e2_stat_q <= wdat[E2_STAT_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read channel, one register slice
  logic [15:0] rd_val;
  logic        rd_hit;

  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr_i)
      ADDR_MODE_CTRL:   rd_val = mode_ctrl_q;
      ADDR_EDGE_SELECT: begin
        rd_val = edge_select_q;
        rd_val[E2_STAT_BIT] = e2_stat_q;
        rd_val[E1_STAT_BIT] = e1_stat_q;
      end
      ADDR_CURRENT:     rd_val = current_q;
      default: begin
        rd_val = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= {16'h0000, rd_val};
      s_axi_rresp_o   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o  <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // analog controls, registered
  logic [3:0] range_oh;

  always_comb begin
    case (range_t'(current_q[RANGE_LSB +: RANGE_W]))
      RANGE_X1:    range_oh = 4'h1;
      RANGE_X10:   range_oh = 4'h2;
      RANGE_X100:  range_oh = 4'h4;
      RANGE_X1000: range_oh = 4'h8;
      default:     range_oh = 4'h1;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      analog_o <= '0;
    end else begin
      analog_o.source_on     <= run & (e1_stat_q ^ e2_stat_q);
      analog_o.source_ground <= mode_ctrl_q[SOURCE_GROUND_BIT];
      analog_o.trim          <= signed'(current_q[TRIM_LSB +: TRIM_W]);
      analog_o.range_onehot  <= range_oh;
    end
  end
endmodule

// >>> common/ctu_pkg.sv
package ctu_pkg;

  // register byte addresses
  localparam logic [3:0] ADDR_MODE_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_EDGE_SELECT = 4'h4;
  localparam logic [3:0] ADDR_CURRENT     = 4'h8;

  // mode control field positions
  localparam int MODE_ENABLE_BIT   = 15;
  localparam int EDGE_PASS_BIT     = 11;
  localparam int EDGE_ORDER_BIT    = 10;
  localparam int SOURCE_GROUND_BIT = 9;
  localparam logic [15:0] MODE_CTRL_MASK = 16'h8e00;

  // edge select control field positions
  localparam int E1_SENS_BIT   = 15;
  localparam int E1_POL_BIT    = 14;
  localparam int E1_SEL_LSB    = 10;
  localparam int E2_STAT_BIT   = 9;
  localparam int E1_STAT_BIT   = 8;
  localparam int E2_SENS_BIT   = 7;
  localparam int E2_POL_BIT    = 6;
  localparam int E2_SEL_LSB    = 2;
  localparam int SEL_W         = 4;
  localparam logic [15:0] EDGE_SELECT_MASK = 16'hfffc;

  // current control fields
  localparam int TRIM_LSB  = 10;
  localparam int TRIM_W    = 6;
  localparam int RANGE_LSB = 8;
  localparam int RANGE_W   = 2;
  localparam logic [15:0] CURRENT_MASK = 16'hff00;

  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  // range decode: one-hot scale selects
  typedef enum logic [1:0] {
    RANGE_X1000 = 2'b00,
    RANGE_X1    = 2'b01,
    RANGE_X10   = 2'b10,
    RANGE_X100  = 2'b11
  } range_t;

  // per-channel configuration carrier
  typedef struct packed {
    logic             sens;
    logic             pol;
    logic [SEL_W-1:0] sel;
  } chan_cfg_t;

  // all candidate trigger sources
  typedef struct packed {
    logic        first_timer;
    logic        ocmp1;
    logic [12:0] pins;
    logic [2:0]  icap;
    logic [2:0]  cmp;
  } edge_src_t;

  // analog-facing controls
  typedef struct packed {
    logic             source_on;
    logic             source_ground;
    logic signed [TRIM_W-1:0] trim;
    logic [3:0]       range_onehot;
  } analog_ctrl_t;

endpackage

// >>> verilog/ctu_sync2.sv
`timescale 1ns/1ps
module ctu_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         arst_n_i,
  // data
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule

// >>> verilog/ctu_edge_chan.sv
`timescale 1ns/1ps
module ctu_edge_chan (
  // clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                arst_n_i,
  // selected, already synchronised source
  input  wire logic                src_i,
  input  wire ctu_pkg::chan_cfg_t  cfg_i,
  input  wire logic                run_i,
  // qualified event; one cycle per edge in edge mode, every cycle the level stands in level mode
  output logic                     event_o
);
  import ctu_pkg::*;

  logic prev_q;
  logic active;

  // polarity folds falling/low onto rising/high
  assign active = cfg_i.pol ? src_i : ~src_i;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= active;
    end
  end

  // level mode fires every cycle the level stands; the status flag makes it sticky
  always_comb begin
    if (!run_i) begin
      event_o = 1'b0;
    end else if (cfg_i.sens) begin
      event_o = active & ~prev_q;
    end else begin
      event_o = active;
    end
  end
endmodule

// >>> verification/ctu_src_model.sv
`timescale 1ns/1ps
module ctu_src_model
  import ctu_pkg::*;
(
  // which source moves, and to what level
  input  wire logic [4:0] idx_i,
  input  wire logic       lvl_i,
  // every trigger source
  output ctu_pkg::edge_src_t src_o
);
  // one source at a time keeps each expected status unambiguous
  assign src_o = edge_src_t'(21'(lvl_i) << idx_i);
endmodule

// >>> verification/ctu_assertions.sv
`timescale 1ns/1ps
module ctu_assertions
  import ctu_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        arst_n_i,
  input wire logic [3:0]  s_axi_awaddr_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0]  s_axi_wstrb_i,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [3:0]  s_axi_araddr_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire ctu_pkg::edge_src_t    edge_src_i,
  input wire ctu_pkg::analog_ctrl_t analog_o
);
  logic [3:0]  aw_q, ar_q;
  logic [15:0] w_q;
  logic [1:0]  settle_q;
  logic        en_q, gnd_q, quiet;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  // mirror lags the register, so checks wait out a write
  assign quiet = !s_axi_bvalid_o && settle_q == 2'h0;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_q <= 4'h0;
      ar_q <= 4'h0;
      w_q <= 16'h0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) aw_q <= s_axi_awaddr_i;
      if (s_axi_arvalid_i && s_axi_arready_o) ar_q <= s_axi_araddr_i;
      if (s_axi_wvalid_i && s_axi_wready_o) w_q <= s_axi_wdata_i[15:0];
    end
  end
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      settle_q <= 2'h0;
      en_q <= 1'b0;
      gnd_q <= 1'b0;
    end else begin
      settle_q <= s_axi_bvalid_o ? 2'h3 : settle_q - {1'b0, settle_q != 2'h0};
      if ($rose(s_axi_bvalid_o) && aw_q == ADDR_MODE_CTRL && s_axi_bresp_o == RESP_OKAY) begin
        en_q <= w_q[MODE_ENABLE_BIT];
        gnd_q <= w_q[SOURCE_GROUND_BIT];
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  chk_rd_unmap:
    assert property (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == 4'hc |=>
      s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h0)
    else $error("unmapped read not refused");
  chk_cur_unimpl:
    assert property (s_axi_rvalid_o && ar_q == ADDR_CURRENT |->
      s_axi_rdata_o[7:0] == 8'h0 && s_axi_rdata_o[31:16] == 16'h0)
    else $error("current register spare bits not zero");
  chk_edge_unimpl:
    assert property (s_axi_rvalid_o && ar_q == ADDR_EDGE_SELECT |-> s_axi_rdata_o[1:0] == 2'h0)
    else $error("edge select spare bits not zero");
  chk_trim_match:
    assert property (s_axi_rvalid_o && ar_q == ADDR_CURRENT |->
      analog_o.trim == s_axi_rdata_o[15:10])
    else $error("trim output differs from register");
  chk_range_decode:
    assert property (s_axi_rvalid_o && ar_q == ADDR_CURRENT |->
      analog_o.range_onehot == 4'h1 << 2'(s_axi_rdata_o[9:8] - 2'h1))
    else $error("range select wrong");
  chk_src_off:
    assert property (!en_q && quiet |-> !analog_o.source_on)
    else $error("source on while unit disabled");
  chk_gnd_follow:
    assert property (quiet |-> analog_o.source_ground == gnd_q)
    else $error("ground control not followed");
  chk_src_xor:
    assert property ($rose(s_axi_rvalid_o) && ar_q == ADDR_EDGE_SELECT && en_q && quiet |->
      analog_o.source_on == ^s_axi_rdata_o[9:8])
    else $error("source state differs from status flags");
  cov_unmap: cover property (s_axi_bvalid_o && s_axi_bresp_o == RESP_SLVERR);
  cov_src_on: cover property (analog_o.source_on);
  cov_ground: cover property (analog_o.source_ground);
endmodule

bind charge_time_unit ctu_assertions u_chk (.*);

// >>> verification/charge_time_unit_tb_top.sv
`timescale 1ns/1ps
module charge_time_unit_tb_top;
  import ctu_pkg::*;
  logic        clk_sys_i = 1'b0, arst_n_i = 1'b0;
  logic [3:0]  s_axi_awaddr_i = 4'h0, s_axi_araddr_i = 4'h0, s_axi_wstrb_i = 4'h0;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, t;
  logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, lvl = 1'b0;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, bq[$];
  logic [4:0]  idx = 5'h0;
  logic [15:0] cfg;
  logic [33:0] rq[$];
  int          n_errors = 0, tests_run = 0, cyc = 0, seed = 21094;
  edge_src_t    edge_src_i;
  analog_ctrl_t analog_o;

  charge_time_unit u_dut (.*);
  ctu_src_model u_src (.idx_i(idx), .lvl_i(lvl), .src_o(edge_src_i));

  always #2 clk_sys_i = ~clk_sys_i;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("Error %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] r = RESP_OKAY);
    logic dn;
    dn = 1'b0;
    bq.push_back(r);
    @(posedge clk_sys_i);
    s_axi_awaddr_i <= a;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wdata_i <= {16'h0, d};
    s_axi_wstrb_i <= 4'hf;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    while (!dn) begin
      @(posedge clk_sys_i);
      if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      if (s_axi_bvalid_o) s_axi_bready_i <= 1'b0;
      dn = s_axi_bvalid_o;
    end
    // let the analog side settle before anyone looks at it
    repeat (2) @(negedge clk_sys_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] d, input logic [1:0] r = RESP_OKAY);
    logic dn;
    dn = 1'b0;
    rq.push_back({r, 16'h0, d});
    @(posedge clk_sys_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    while (!dn) begin
      @(posedge clk_sys_i);
      if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      if (s_axi_rvalid_o) s_axi_rready_i <= 1'b0;
      dn = s_axi_rvalid_o;
    end
  endtask
  task automatic ev(input logic [4:0] b, input logic l);
    @(posedge clk_sys_i);
    idx <= b;
    lvl <= l;
    repeat (6) @(posedge clk_sys_i);
  endtask
  task automatic pl(input logic [4:0] b);
    ev(b, 1'b1);
    ev(b, 1'b0);
  endtask
  // flat bit of a source code in the source bundle
  function automatic logic [4:0] src_bit(input int ch, input int c);
    return 5'(c == 0 ? 20 : c == 1 ? 19 : c == 2 ? 7 : c == 3 ? 6 :
      ch == 1 ? (c < 10 ? c + 4 : c < 13 ? c - 7 : c - 13) :
      (c < 9 ? c + 10 : c < 12 ? c - 6 : c - 13));
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys_i) begin
    if (s_axi_rvalid_o && s_axi_rready_i && rq.size() > 0) chk({s_axi_rresp_o, s_axi_rdata_o}, rq.pop_front());
    if (s_axi_bvalid_o && s_axi_bready_i && bq.size() > 0) chk({32'h0, s_axi_bresp_o}, {32'h0, bq.pop_front()});
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    rd(ADDR_MODE_CTRL, 16'h0);
    rd(ADDR_EDGE_SELECT, 16'h0);
    rd(ADDR_CURRENT, 16'h0);
    chk({30'h0, analog_o.range_onehot}, 34'h8);
    wr(ADDR_EDGE_SELECT, 16'hffff);
    rd(ADDR_EDGE_SELECT, EDGE_SELECT_MASK);
    wr(ADDR_CURRENT, 16'hffff);
    rd(ADDR_CURRENT, CURRENT_MASK);
    wr(ADDR_MODE_CTRL, 16'hffff);
    rd(ADDR_MODE_CTRL, MODE_CTRL_MASK);
    chk({33'h0, analog_o.source_ground}, 34'h1);
    wr(4'hc, 16'hffff, RESP_SLVERR);
    rd(4'hc, 16'h0, RESP_SLVERR);
    wr(ADDR_MODE_CTRL, 16'h0000);
    chk({33'h0, analog_o.source_ground}, 34'h0);
    for (int r = 0; r < 4; r++) begin
      t = $random(seed);
      cfg = {t[5:0], 2'(r), 8'h00};
      wr(ADDR_CURRENT, cfg);
      rd(ADDR_CURRENT, cfg);
      chk({30'h0, analog_o.range_onehot}, 34'(4'h1 << ((r + 3) % 4)));
      chk({28'h0, analog_o.trim}, {28'h0, t[5:0]});
    end
    // every source code of both channels except channel two's reserved code 12, rising edge
    wr(ADDR_MODE_CTRL, 16'h8800);
    for (int ch = 1; ch < 3; ch++) begin
      for (int c = 0; c < 16; c++) begin
        if (ch == 2 && c == 12) continue;
        cfg = ch == 1 ? {2'b11, 4'(c), 10'h0d0} : {8'he4, 2'b11, 4'(c), 2'b00};
        wr(ADDR_EDGE_SELECT, cfg);
        ev(src_bit(ch, c), 1'b1);
        rd(ADDR_EDGE_SELECT, cfg | (ch == 1 ? 16'h0100 : 16'h0200));
        chk({33'h0, analog_o.source_on}, 34'h1);
        wr(ADDR_EDGE_SELECT, cfg);
        rd(ADDR_EDGE_SELECT, cfg);
        ev(src_bit(ch, c), 1'b0);
      end
    end
    wr(ADDR_MODE_CTRL, 16'h8c00);
    wr(ADDR_EDGE_SELECT, 16'he4d0);
    pl(5'd14);
    rd(ADDR_EDGE_SELECT, 16'he4d0);
    pl(5'd13);
    pl(5'd14);
    rd(ADDR_EDGE_SELECT, 16'he7d0);
    chk({33'h0, analog_o.source_on}, 34'h0);
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_MODE_CTRL, m == 0 ? 16'h8000 : 16'h0800);
      wr(ADDR_EDGE_SELECT, 16'he4d0);
      pl(5'd13);
      rd(ADDR_EDGE_SELECT, 16'he4d0);
    end
    wr(ADDR_EDGE_SELECT, 16'h0100);
    chk({33'h0, analog_o.source_on}, 34'h0);
    wr(ADDR_MODE_CTRL, 16'h8000);
    for (int k = 1; k < 4; k++) begin
      wr(ADDR_EDGE_SELECT, 16'(k << 8));
      chk({33'h0, analog_o.source_on}, 34'(k != 3));
    end
    // level-low, then falling edge on channel one; the select is changed while
    // edges are blocked, since the old level-low timer setup would keep flag two set
    wr(ADDR_EDGE_SELECT, 16'h24d0);
    wr(ADDR_MODE_CTRL, 16'h8800);
    ev(5'd13, 1'b0);
    rd(ADDR_EDGE_SELECT, 16'h25d0);
    ev(5'd13, 1'b1);
    wr(ADDR_EDGE_SELECT, 16'ha4d0);
    ev(5'd13, 1'b1);
    rd(ADDR_EDGE_SELECT, 16'ha4d0);
    ev(5'd13, 1'b0);
    rd(ADDR_EDGE_SELECT, 16'ha5d0);
    repeat (4) @(posedge clk_sys_i);
    final_report();
  end
endmodule
